//--- verilog/t2s_top.sv
/*
 * Timer 2 with capture, auto-reload and baud generator modes, plus two
 * serial ports, behind an AHB-Lite slave. Assumes the master leaves an
 * idle cycle between transfers and timer1_overflow is a hclk pulse.
 */
// Notes on behaviour
// (RQ1) overflow sets control bit 7; it stays until software clears it
// (RQ2) no overflow flag while any serial clock select is set
// (RQ3) trigger edge with enable sets bit 6; software alone clears it
// (RQ4) either flag raises the shared timer interrupt when enabled
// (RQ5) bit 5 picks this timer as port 1 receive clock, else timer 1
// (RQ6) bit 4 picks this timer as port 1 transmit clock, else timer 1
// (RQ7) trigger enable bit 3 gates falling trigger edges
// (RQ8) timer counts only while run bit 2 is set
// (RQ9) bit 1 picks machine cycles or falling count-input edges
// (RQ10) bit 0 picks capture on trigger or reload on overflow/trigger
// (RQ11) any clock select forces reload on overflow, ignoring bit 0
// (RQ12) power control holds port 2 receive and transmit clock selects
// (RQ13) capture mode without trigger is a plain up-counting timer
// (RQ14) in baud mode a trigger edge only sets the external flag
// (RQ15) receiver is double-buffered; a late read loses a byte
// (RQ16) buffer write feeds transmitter, read returns separate receiver
// (RQ17) mode 0: data on receive pin, clock on transmit pin, 8 bits
// (RQ18) mode 1: start, 8 data, stop; stop goes to received ninth bit
// (RQ19) mode 2: 11 bits, ninth bit from control, fixed 1/32 or 1/64
// (RQ20) mode 3 framed as mode 2 with timer-driven rate
// (RQ21) writing the serial buffer starts a transmission
// (RQ22) mode 0 receives when done flag clear; others on start bit
// (RQ23) capture copies count low/high into capture low/high
// (RQ24) reload copies capture low/high into the count
// (RQ25) timer-driven serial rate is overflow rate over sixteen
// (RQ26) receiver finds start edge and samples mid-bit at 16x
`timescale 1ns/10ps
module t2s_top #(
  parameter int MC_DIV = t2s_pkg::MC_CYCLES
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // timer inputs and interrupt
  input  wire logic        external_count_input,
  input  wire logic        external_trigger_input,
  input  wire logic        timer1_overflow,
  output logic             timer_irq,
  // first serial port
  input  wire logic        rxd1_in,
  output logic             rxd1_out,
  output logic             rxd1_oe,
  output logic             txd1,
  // second serial port
  input  wire logic        rxd2_in,
  output logic             rxd2_out,
  output logic             rxd2_oe,
  output logic             txd2
);
  if (MC_DIV < 2 || MC_DIV > 15) begin : g_chk
    $error("MC_DIV must lie in 2..15");
  end

  localparam logic [3:0] MC_LAST = 4'(MC_DIV - 1);

  // flags: hardware set wins over a software write of zero
  function automatic logic [7:0] flag_upd(input logic [7:0] old,
                                          input logic [7:0] wdat,
                                          input logic       wen,
                                          input logic [7:0] set);
    flag_upd = (wen ? wdat : old) | set;
  endfunction

  logic [7:0]  ctrl_q, power_control_reg_q, rd_d;
  logic [7:0]  serial_control_q [2];
  logic [15:0] cnt_q, cap_q;
  logic [7:0]  wa_q;
  logic        wv_q;
  logic [3:0]  pre_q;
  logic [3:0]  syn;
  logic        cnt_prev_q, trg_prev_q, t2ovf_q;
  logic        mc_tick, cnt_fall, trg_fall, baud, inc, ovf, trig;
  logic        reload, capture, wen_ctrl, wen_cntl, wen_cnth;
  logic        wen_capl, wen_caph;
  logic [1:0]  wen_serial_control, wen_serial_buffer, ovf_rx, ovf_tx, ti_set, ri_set;
  logic [1:0]  rb8, u_rxo, u_oe, u_txd, rxd_s;
  logic [7:0]  rx_data [2];
  logic [7:0]  wd;

  // bus slave: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wv_q      <= 1'b0;
      wa_q      <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wv_q <= hsel & hready & htrans[1] & hwrite & (hsize == 3'h2);
      wa_q <= haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite)
        hrdata <= {24'h00_0000, rd_d};
    end
  end

  // unmapped offsets read zero; writes there are dropped
  always_comb begin
    rd_d = 8'h00;
    case (haddr[7:0])
      t2s_pkg::ADDR_CTRL:  rd_d = ctrl_q;
      t2s_pkg::ADDR_CAPL:  rd_d = cap_q[7:0];
      t2s_pkg::ADDR_CAPH:  rd_d = cap_q[15:8];
      t2s_pkg::ADDR_CNTL:  rd_d = cnt_q[7:0];
      t2s_pkg::ADDR_CNTH:  rd_d = cnt_q[15:8];
      t2s_pkg::ADDR_POWER_CONTROL_REG:  rd_d = power_control_reg_q;
      t2s_pkg::ADDR_SCON1: rd_d = serial_control_q[0];
      t2s_pkg::ADDR_SBUF1: rd_d = rx_data[0]; // RQ16
      t2s_pkg::ADDR_SERIAL_CONTROL_PORT2: rd_d = serial_control_q[1];
      t2s_pkg::ADDR_SERIAL_BUFFER_PORT2: rd_d = rx_data[1]; // RQ16
      default:             rd_d = 8'h00;
    endcase
  end

  assign wd          = hwdata[7:0];
  assign wen_ctrl    = wv_q & (wa_q == t2s_pkg::ADDR_CTRL);
  assign wen_capl    = wv_q & (wa_q == t2s_pkg::ADDR_CAPL);
  assign wen_caph    = wv_q & (wa_q == t2s_pkg::ADDR_CAPH);
  assign wen_cntl    = wv_q & (wa_q == t2s_pkg::ADDR_CNTL);
  assign wen_cnth    = wv_q & (wa_q == t2s_pkg::ADDR_CNTH);
  assign wen_serial_control[0] = wv_q & (wa_q == t2s_pkg::ADDR_SCON1);
  assign wen_serial_control[1] = wv_q & (wa_q == t2s_pkg::ADDR_SERIAL_CONTROL_PORT2);
  assign wen_serial_buffer[0] = wv_q & (wa_q == t2s_pkg::ADDR_SBUF1);
  assign wen_serial_buffer[1] = wv_q & (wa_q == t2s_pkg::ADDR_SERIAL_BUFFER_PORT2);

  t2s_sync #(.W(4)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     ({rxd2_in, rxd1_in, external_trigger_input,
               external_count_input}),
    .dout    (syn)
  );
  assign rxd_s = syn[3:2];

  // machine-cycle prescaler and edge detectors
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_q      <= 4'h0;
      cnt_prev_q <= 1'b1;
      trg_prev_q <= 1'b1;
    end else begin
      pre_q      <= (pre_q == MC_LAST) ? 4'h0 : pre_q + 4'h1;
      cnt_prev_q <= syn[0];
      trg_prev_q <= syn[1];
    end
  end

  assign mc_tick  = (pre_q == MC_LAST);
  assign cnt_fall = cnt_prev_q & ~syn[0];
  assign trg_fall = trg_prev_q & ~syn[1];
  assign baud     = ctrl_q[t2s_pkg::CTRL_RCLK] | ctrl_q[t2s_pkg::CTRL_TX_CLOCK_SELECT]
                  | power_control_reg_q[t2s_pkg::POWER_CONTROL_REG_RCLK2]
                  | power_control_reg_q[t2s_pkg::POWER_CONTROL_REG_TCLK2];
  assign inc = ctrl_q[t2s_pkg::CTRL_RUN] // RQ8
             & (ctrl_q[t2s_pkg::CTRL_CST] ? cnt_fall : mc_tick); // RQ9
  assign ovf  = inc & (cnt_q == 16'hFFFF); // RQ13
  assign trig = ctrl_q[t2s_pkg::CTRL_TEN] & trg_fall; // RQ7
  assign reload = (ovf & (baud | ~ctrl_q[t2s_pkg::CTRL_CPRL])) // RQ10 RQ11
                | (trig & ~baud & ~ctrl_q[t2s_pkg::CTRL_CPRL]); // RQ14
  assign capture = trig & ~baud & ctrl_q[t2s_pkg::CTRL_CPRL]; // RQ10

  // count register; a software write beats a same-cycle count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= t2s_pkg::CNT_RST;
    end else if (wen_cntl || wen_cnth) begin
      if (wen_cntl) cnt_q[7:0]  <= wd;
      if (wen_cnth) cnt_q[15:8] <= wd;
    end else if (reload) begin
      cnt_q <= cap_q; // RQ24
    end else if (inc) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // capture registers; a capture beats a same-cycle write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_q <= t2s_pkg::CAP_RST;
    end else if (capture) begin
      cap_q <= cnt_q; // RQ23
    end else begin
      if (wen_capl) cap_q[7:0]  <= wd;
      if (wen_caph) cap_q[15:8] <= wd;
    end
  end

  // control register and overflow pulse to the serial ports
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q  <= t2s_pkg::CTRL_RST;
      t2ovf_q <= 1'b0;
    end else begin
      ctrl_q  <= flag_upd(ctrl_q, wd, wen_ctrl,
                          {ovf & ~baud, trig, 6'h00}); // RQ1 RQ2 RQ3
      t2ovf_q <= ovf;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      power_control_reg_q <= t2s_pkg::POWER_CONTROL_REG_RST;
    else if (wv_q && wa_q == t2s_pkg::ADDR_POWER_CONTROL_REG)
      power_control_reg_q <= wd; // RQ12
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) timer_irq <= 1'b0;
    else timer_irq <= power_control_reg_q[t2s_pkg::POWER_CONTROL_REG_IRQEN] // RQ4
                    & (ctrl_q[t2s_pkg::CTRL_TF] | ctrl_q[t2s_pkg::CTRL_EXF]);
  end

  // serial clock sources
  assign ovf_rx[0] = ctrl_q[t2s_pkg::CTRL_RCLK] ? t2ovf_q
                                                : timer1_overflow; // RQ5
  assign ovf_tx[0] = ctrl_q[t2s_pkg::CTRL_TX_CLOCK_SELECT] ? t2ovf_q
                                                : timer1_overflow; // RQ6
  assign ovf_rx[1] = power_control_reg_q[t2s_pkg::POWER_CONTROL_REG_RCLK2] ? t2ovf_q
                                                 : timer1_overflow; // RQ12
  assign ovf_tx[1] = power_control_reg_q[t2s_pkg::POWER_CONTROL_REG_TCLK2] ? t2ovf_q
                                                 : timer1_overflow; // RQ12

  for (genvar p = 0; p < 2; p++) begin : g_port
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        serial_control_q[p] <= t2s_pkg::SERIAL_CONTROL_RST;
      end else begin
        serial_control_q[p] <= flag_upd(serial_control_q[p], wd, wen_serial_control[p],
                              {5'h00, 1'b0, ti_set[p], ri_set[p]});
        if (ri_set[p]) serial_control_q[p][t2s_pkg::SERIAL_CONTROL_RB8] <= rb8[p];
      end
    end

    t2s_uart u_uart (
      .hclk    (hclk),
      .hresetn (hresetn),
      .mode    (t2s_pkg::t2s_mode_t'(serial_control_q[p][7:6])),
      .ren     (serial_control_q[p][t2s_pkg::SERIAL_CONTROL_REN]),
      .smod    (power_control_reg_q[t2s_pkg::POWER_CONTROL_REG_SMOD]),
      .tb8     (serial_control_q[p][t2s_pkg::SERIAL_CONTROL_TB8]),
      .ri      (serial_control_q[p][t2s_pkg::SERIAL_CONTROL_RI]),
      .ovf_rx  (ovf_rx[p]),
      .ovf_tx  (ovf_tx[p]),
      .tx_load (wen_serial_buffer[p]), // RQ16
      .tx_data (wd),
      .rxd_in  (rxd_s[p]),
      .rxd_out (u_rxo[p]),
      .rxd_oe  (u_oe[p]),
      .txd     (u_txd[p]),
      .rx_data (rx_data[p]),
      .rb8     (rb8[p]),
      .ti_set  (ti_set[p]),
      .ri_set  (ri_set[p])
    );
  end

  // pins leave through flip-flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxd1_out <= 1'b1; rxd1_oe <= 1'b0; txd1 <= 1'b1;
      rxd2_out <= 1'b1; rxd2_oe <= 1'b0; txd2 <= 1'b1;
    end else begin
      rxd1_out <= u_rxo[0]; rxd1_oe <= u_oe[0]; txd1 <= u_txd[0];
      rxd2_out <= u_rxo[1]; rxd2_oe <= u_oe[1]; txd2 <= u_txd[1];
    end
  end

  // checks
  AST_TF_SET: assert property (@(posedge hclk) disable iff (!hresetn)
    ovf && !baud |=> ctrl_q[t2s_pkg::CTRL_TF]) // RQ1
    else $error("overflow did not set the overflow flag");
  AST_TF_BAUD: assert property (@(posedge hclk) disable iff (!hresetn)
    baud && !ctrl_q[t2s_pkg::CTRL_TF] && !wen_ctrl
    |=> !ctrl_q[t2s_pkg::CTRL_TF]) // RQ2
    else $error("overflow flag set in baud generator operation");
  AST_EXF_SET: assert property (@(posedge hclk) disable iff (!hresetn)
    trig |=> ctrl_q[t2s_pkg::CTRL_EXF]) // RQ3
    else $error("trigger edge did not set the external flag");
  AST_TRIG_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl_q[t2s_pkg::CTRL_TEN] && !ctrl_q[t2s_pkg::CTRL_EXF] && !wen_ctrl
    |=> !ctrl_q[t2s_pkg::CTRL_EXF]) // RQ7
    else $error("external flag set with trigger disabled");
  AST_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
    power_control_reg_q[t2s_pkg::POWER_CONTROL_REG_IRQEN] && ctrl_q[t2s_pkg::CTRL_EXF]
    |=> timer_irq) // RQ4
    else $error("external flag did not raise the interrupt");
  AST_STOP: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl_q[t2s_pkg::CTRL_RUN] && !trig && !wen_cntl && !wen_cnth
    |=> $stable(cnt_q)) // RQ8
    else $error("count moved while stopped");
  AST_MC_RATE: assert property (@(posedge hclk) disable iff (!hresetn)
    inc && !ctrl_q[t2s_pkg::CTRL_CST] && !wen_ctrl
    |=> !inc [*8]) // RQ9
    else $error("internal count faster than the machine cycle");
  AST_CAPTURE: assert property (@(posedge hclk) disable iff (!hresetn)
    capture |=> cap_q == $past(cnt_q)) // RQ23
    else $error("capture did not copy the count");
  AST_RELOAD: assert property (@(posedge hclk) disable iff (!hresetn)
    reload && !wen_cntl && !wen_cnth |=> cnt_q == $past(cap_q)) // RQ24
    else $error("reload did not copy the capture registers");
  AST_BAUD_RELOAD: assert property (@(posedge hclk) disable iff (!hresetn)
    ovf && baud && ctrl_q[t2s_pkg::CTRL_CPRL] && !wen_cntl && !wen_cnth
    |=> cnt_q == $past(cap_q)) // RQ11
    else $error("baud mode overflow did not reload");
  AST_BAUD_TRIG: assert property (@(posedge hclk) disable iff (!hresetn)
    trig && baud && !inc && !wen_cntl && !wen_cnth
    |=> $stable(cnt_q) && ctrl_q[t2s_pkg::CTRL_EXF]) // RQ14
    else $error("baud mode trigger touched the count");

  COV_CAPTURE: cover property (@(posedge hclk) disable iff (!hresetn)
    capture);
  COV_OVF_RELOAD: cover property (@(posedge hclk) disable iff (!hresetn)
    ovf && !baud);
  COV_BAUD_OVF: cover property (@(posedge hclk) disable iff (!hresetn)
    ovf && baud);
  COV_RX1: cover property (@(posedge hclk) disable iff (!hresetn)
    ri_set[0]);
endmodule

//--- common/t2s_pkg.sv
/*
 * Shared constants for the timer/serial block: register offsets, field
 * positions, reset values, serial mode codes and cycle counts.
 * Assumes a 100 MHz hclk that stands in for the oscillator clock.
 */
package t2s_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_CAPL  = 8'h04;
  localparam logic [7:0] ADDR_CAPH  = 8'h08;
  localparam logic [7:0] ADDR_CNTL  = 8'h0C;
  localparam logic [7:0] ADDR_CNTH  = 8'h10;
  localparam logic [7:0] ADDR_POWER_CONTROL_REG  = 8'h14;
  localparam logic [7:0] ADDR_SCON1 = 8'h18;
  localparam logic [7:0] ADDR_SBUF1 = 8'h1C;
  localparam logic [7:0] ADDR_SERIAL_CONTROL_PORT2 = 8'h20;
  localparam logic [7:0] ADDR_SERIAL_BUFFER_PORT2 = 8'h24;
  // timer2_control fields
  localparam int CTRL_TF   = 7;
  localparam int CTRL_EXF  = 6;
  localparam int CTRL_RCLK = 5;
  localparam int CTRL_TX_CLOCK_SELECT = 4;
  localparam int CTRL_TEN  = 3;
  localparam int CTRL_RUN  = 2;
  localparam int CTRL_CST  = 1;
  localparam int CTRL_CPRL = 0;
  // power_control_reg fields
  localparam int POWER_CONTROL_REG_SMOD  = 7;
  localparam int POWER_CONTROL_REG_RCLK2 = 5;
  localparam int POWER_CONTROL_REG_TCLK2 = 4;
  localparam int POWER_CONTROL_REG_IRQEN = 0;
  // serial_control fields
  localparam int SERIAL_CONTROL_REN = 4;
  localparam int SERIAL_CONTROL_TB8 = 3;
  localparam int SERIAL_CONTROL_RB8 = 2;
  localparam int SERIAL_CONTROL_TI  = 1;
  localparam int SERIAL_CONTROL_RI  = 0;
  // reset values
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [7:0]  POWER_CONTROL_REG_RST = 8'h00;
  localparam logic [7:0]  SERIAL_CONTROL_RST = 8'h00;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [15:0] CAP_RST  = 16'h0000;
  // timing counts in hclk cycles; OVS_LAST and OVS_MID count oversampling ticks
  localparam int         MC_CYCLES = 12;
  localparam logic [3:0] M0_LAST   = 4'hB;
  localparam logic [3:0] M0_HALF   = 4'h6;
  localparam logic [3:0] OVS_LAST  = 4'hF;
  localparam logic [3:0] OVS_MID   = 4'h7;
  typedef enum logic [1:0] {
    T2S_SHIFT = 2'b00,
    T2S_UART8 = 2'b01,
    T2S_FIX9  = 2'b10,
    T2S_VAR9  = 2'b11
  } t2s_mode_t;
endpackage

//--- verilog/t2s_sync.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes pins idle high; the filtered level changes only when the
 * second and third stages agree.
 */
`timescale 1ns/10ps
module t2s_sync #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // raw and filtered levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_q, s2_q, s3_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      dout <= '1;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      dout <= (s2_q & s3_q) | (dout & (s2_q ^ s3_q));
    end
  end
endmodule

//--- verilog/t2s_uart.sv
/*
 * One standard serial port: shift mode 0 and async modes 1 to 3.
 * Assumes synchronised receive input and one-cycle overflow pulses
 * for the variable-rate modes; flags sit in the parent, the rx_data buffer here.
 */
`timescale 1ns/10ps
module t2s_uart (
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // control
  input  wire t2s_pkg::t2s_mode_t   mode,
  input  wire logic                 ren,
  input  wire logic                 smod,
  input  wire logic                 tb8,
  input  wire logic                 ri,
  input  wire logic                 ovf_rx,
  input  wire logic                 ovf_tx,
  input  wire logic                 tx_load,
  input  wire logic [7:0]           tx_data,
  // pins
  input  wire logic                 rxd_in,
  output logic                      rxd_out,
  output logic                      rxd_oe,
  output logic                      txd,
  // received data and events
  output logic [7:0]                rx_data,
  output logic                      rb8,
  output logic                      ti_set,
  output logic                      ri_set
);
  logic [1:0]  div_q;
  logic        fix_tick, rx_t, tx_t, m0, m0rx_q, m0_done_q, samp_q;
  logic        tbusy_q, rbusy_q, rprev_q;
  logic [10:0] tsr_q;
  logic [9:0]  rsr_q;
  logic [3:0]  tph_q, tbit_q, rph_q, rbit_q, stop_idx;

  assign m0       = (mode == t2s_pkg::T2S_SHIFT);
  assign fix_tick = smod ? div_q[0] : (div_q == 2'h3);
  assign rx_t     = (mode == t2s_pkg::T2S_FIX9) ? fix_tick : ovf_rx;
  assign tx_t     = (mode == t2s_pkg::T2S_FIX9) ? fix_tick : ovf_tx;
  assign stop_idx = (mode == t2s_pkg::T2S_UART8) ? 4'h9 : 4'hA;
  assign rxd_out  = tsr_q[0];
  assign rxd_oe   = tbusy_q & m0 & ~m0rx_q;
  assign txd = !tbusy_q ? 1'b1 : m0 ? (tph_q >= t2s_pkg::M0_HALF)
                                    : tsr_q[0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) div_q <= 2'h0;
    else          div_q <= div_q + 2'h1;
  end

  // transmit engine, also the mode 0 shifter in both directions
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tsr_q <= '1; tph_q <= 4'h0; tbit_q <= 4'h0; tbusy_q <= 1'b0;
      m0rx_q <= 1'b0; samp_q <= 1'b1; ti_set <= 1'b0; m0_done_q <= 1'b0;
    end else begin
      ti_set    <= 1'b0;
      m0_done_q <= 1'b0;
      if (!tbusy_q) begin
        tph_q  <= 4'h0;
        tbit_q <= 4'h0;
        if (tx_load) begin // RQ21
          tbusy_q <= 1'b1;
          m0rx_q  <= 1'b0;
          tsr_q   <= m0 ? {3'h7, tx_data} // RQ17
                        : {1'b1, (mode == t2s_pkg::T2S_UART8) | tb8,
                           tx_data, 1'b0}; // RQ18 RQ19 RQ20
        end else if (m0 && ren && !ri) begin // RQ22
          tbusy_q <= 1'b1;
          m0rx_q  <= 1'b1;
          tsr_q   <= '1;
        end
      end else if (m0) begin
        tph_q <= (tph_q == t2s_pkg::M0_LAST) ? 4'h0 : tph_q + 4'h1;
        if (tph_q == t2s_pkg::M0_HALF) samp_q <= rxd_in;
        if (tph_q == t2s_pkg::M0_LAST) begin
          tsr_q  <= {3'h7, m0rx_q ? samp_q : 1'b1, tsr_q[7:1]}; // RQ17
          tbit_q <= tbit_q + 4'h1;
          if (tbit_q == 4'h7) begin
            tbusy_q   <= 1'b0;
            ti_set    <= ~m0rx_q;
            m0_done_q <= m0rx_q;
          end
        end
      end else if (tx_t) begin // RQ25
        tph_q <= tph_q + 4'h1;
        if (tph_q == t2s_pkg::OVS_LAST) begin
          tsr_q  <= {1'b1, tsr_q[10:1]};
          tbit_q <= tbit_q + 4'h1;
          if (tbit_q == stop_idx - 4'h1) ti_set <= 1'b1;
          if (tbit_q == stop_idx) tbusy_q <= 1'b0;
        end
      end
    end
  end

  // receive engine; a finished byte is dropped while ri is still set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rsr_q <= '1; rph_q <= 4'h0; rbit_q <= 4'h0; rbusy_q <= 1'b0;
      rprev_q <= 1'b1; rx_data <= 8'h00; rb8 <= 1'b0; ri_set <= 1'b0;
    end else begin
      ri_set  <= 1'b0;
      rprev_q <= rxd_in;
      if (m0_done_q) begin
        if (!ri) begin // RQ15
          rx_data <= tsr_q[7:0];
          ri_set  <= 1'b1;
        end
      end else if (!rbusy_q) begin
        rph_q  <= 4'h0;
        rbit_q <= 4'h0;
        if (!m0 && ren && rprev_q && !rxd_in) rbusy_q <= 1'b1; // RQ22 RQ26
      end else if (m0 || !ren) begin
        rbusy_q <= 1'b0;
      end else if (rx_t) begin
        rph_q <= rph_q + 4'h1;
        if (rph_q == t2s_pkg::OVS_MID) begin // RQ26
          rsr_q  <= {rxd_in, rsr_q[9:1]};
          rbit_q <= rbit_q + 4'h1;
          if (rbit_q == 4'h0 && rxd_in) rbusy_q <= 1'b0;
          if (rbit_q == 4'h9) begin
            rbusy_q <= 1'b0;
            if (!ri) begin // RQ15
              rx_data <= rsr_q[9:2];
              rb8     <= rxd_in; // RQ18 RQ19
              ri_set  <= 1'b1;
            end
          end
        end
      end
    end
  end
endmodule

//--- tb/t2s_far_end.sv
/* far-end serial partner on port 1: sends 10-bit frames on rxd and
   decodes frames seen on txd. assumes bit time BIT_CYC set by bench */
`timescale 1ns/10ps
module t2s_far_end #(
  parameter int BIT_CYC = 32
) (
  // clock
  input  wire logic hclk,
  // serial lines
  input  wire logic txd,
  output logic      rxd
);
  logic [7:0] got;
  initial rxd = 1'h1;
  initial got = 8'h00;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BIT_CYC) @(posedge hclk);
    end
  endtask
  // stop bit not checked, only data
  always begin
    @(negedge txd);
    repeat (BIT_CYC / 2) @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge hclk);
      got[i] = txd;
    end
  end
endmodule

//--- tb/t2s_top_bench.sv
/* bench for t2s_top: registers over AHB-Lite, timer modes, port 1.
   assumes MC_DIV of 2, so one baud overflow every 2 cycles */
`timescale 1ns/10ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
  n_mismatch++; $display("mismatch %s exp %h got %h", n, e, s); end end
module t2s_top_bench;
  logic        hclk = 1'h0;
  logic        hresetn;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        trig;
  logic        irq;
  logic        rxd1;
  logic        txd1;
  logic        hsel = 1'h1;
  logic        cnt_in = 1'h1;
  logic        t1ovf = 1'h0;
  int          n_mismatch = 0;
  int          num_checks = 0;
  always #5 hclk = ~hclk;
  t2s_top #(.MC_DIV(2)) u_t2s_top (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .external_count_input(cnt_in),
    .external_trigger_input(trig), .timer1_overflow(t1ovf),
    .timer_irq(irq), .rxd1_in(rxd1), .rxd1_out(), .rxd1_oe(),
    .txd1(txd1), .rxd2_in(1'h1), .rxd2_out(), .rxd2_oe(), .txd2());
  t2s_far_end #(.BIT_CYC(32)) u_t2s_far_end (.hclk(hclk), .txd(txd1),
    .rxd(rxd1));
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [7:0] d, output logic [31:0] r);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    r = hrdata;
    // idle gap so a read after a write sees the new value
    @(posedge hclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(a, 1'h1, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] r;
    bus(a, 1'h0, 8'h00, r);
    `CHK($sformatf("reg %h", a), {24'h0, e}, r)
  endtask
  task automatic pulse;
    trig <= 1'h0;
    repeat (8) @(posedge hclk);
    trig <= 1'h1;
    repeat (8) @(posedge hclk);
  endtask
  task automatic test_done;
    if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    test_done;
  end
  initial begin
    hresetn = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hwdata = 32'h0;
    trig = 1'h1;
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rd(t2s_pkg::ADDR_CTRL, 8'h00);
    rd(8'h40, 8'h00);
    wr(t2s_pkg::ADDR_CAPH, 8'h12);
    wr(t2s_pkg::ADDR_CNTL, 8'hFE);
    wr(t2s_pkg::ADDR_CNTH, 8'hFF);
    wr(t2s_pkg::ADDR_CTRL, 8'h04);
    repeat (20) @(posedge hclk);
    rd(t2s_pkg::ADDR_CTRL, 8'h84);
    rd(t2s_pkg::ADDR_CNTH, 8'h12);
    wr(t2s_pkg::ADDR_CTRL, 8'h04);
    rd(t2s_pkg::ADDR_CTRL, 8'h04);
    wr(t2s_pkg::ADDR_CNTH, 8'h55);
    wr(t2s_pkg::ADDR_CTRL, 8'h0D);
    wr(t2s_pkg::ADDR_POWER_CONTROL_REG, 8'h01);
    pulse;
    `CHK("irq", 1'h1, irq)
    rd(t2s_pkg::ADDR_CTRL, 8'h4D);
    rd(t2s_pkg::ADDR_CAPH, 8'h55);
    wr(t2s_pkg::ADDR_CTRL, 8'h05);
    pulse;
    rd(t2s_pkg::ADDR_CTRL, 8'h05);
    `CHK("irq", 1'h0, irq)
    wr(t2s_pkg::ADDR_CTRL, 8'h00);
    wr(t2s_pkg::ADDR_CNTL, 8'h77);
    repeat (20) @(posedge hclk);
    rd(t2s_pkg::ADDR_CNTL, 8'h77);
    wr(t2s_pkg::ADDR_POWER_CONTROL_REG, 8'h00);
    wr(t2s_pkg::ADDR_CAPL, 8'hFF);
    wr(t2s_pkg::ADDR_CAPH, 8'hFF);
    wr(t2s_pkg::ADDR_CNTH, 8'hFF);
    // start at all ones so the baud overflows run before the frame
    wr(t2s_pkg::ADDR_CNTL, 8'hFF);
    wr(t2s_pkg::ADDR_CTRL, 8'h34);
    wr(t2s_pkg::ADDR_SCON1, 8'h50);
    repeat (40) @(posedge hclk);
    rd(t2s_pkg::ADDR_CTRL, 8'h34);
    wr(t2s_pkg::ADDR_CTRL, 8'h3C);
    pulse;
    rd(t2s_pkg::ADDR_CTRL, 8'h7C);
    u_t2s_far_end.send(8'hA5);
    repeat (40) @(posedge hclk);
    rd(t2s_pkg::ADDR_SBUF1, 8'hA5);
    rd(t2s_pkg::ADDR_SCON1, 8'h55);
    wr(t2s_pkg::ADDR_SCON1, 8'h50);
    wr(t2s_pkg::ADDR_SBUF1, 8'h3C);
    repeat (420) @(posedge hclk);
    `CHK("far rx", 8'h3C, u_t2s_far_end.got)
    rd(t2s_pkg::ADDR_SCON1, 8'h52);
    rd(t2s_pkg::ADDR_SBUF1, 8'hA5);
    test_done;
  end
endmodule
